// file: dv/midi_host_model.sv
/*
 * Far-side model of the byte link: a controller that takes sent bytes and keeps them in order.
 * Assumes the bench reads the got queue and clears it between transfers.
 */
`timescale 1ns/1ps
module midi_host_model (
	input  logic       clk,
	input  logic       rst,
	input  logic [7:0] tx_data,
	input  logic       tx_valid,
	output logic       tx_ready,
	input  logic       slow
);
	logic [7:0] got [$];
	logic [1:0] ph_q;

	// Every fourth cycle the port stalls when slow, so the two-entry buffer must hold its word.
	always @(posedge clk)
	begin
		if (tx_valid === 1'b1 && tx_ready === 1'b1)
			got.push_back(tx_data);
		ph_q     <= rst ? 2'h0 : ph_q + 2'h1;
		tx_ready <= !rst && !(slow && ph_q == 2'h2);
	end
endmodule

// file: dv/sysex_handler_tb.sv
/*
 * Bench for the exclusive message handler: sends requests and dumps, judges the answers.
 * Assumes the stall-capable controller model sits on the transmit side.
 */
`timescale 1ns/1ps
module sysex_handler_tb;
	import sysex_pkg::*;
	localparam logic [7:0] M  = 8'h11;	// Arbitrary value.
	localparam logic [7:0] P  = 8'h22;	// Arbitrary value.
	localparam logic [3:0] CH = 4'h9;
	logic       clk      = 1'b0;
	logic       rst      = 1'b1;
	logic [7:0] rx_data  = 8'h00;
	logic       rx_valid = 1'b0;
	logic       slow     = 1'b0;
	logic       err_seen = 1'b0;
	logic       rx_ready, tx_valid, tx_ready, sum_error;
	logic [7:0] tx_data;
	panel_evt_t edit_evt = '0;
	panel_evt_t knob_evt = '0;
	panel_evt_t recall_evt = '0;
	logic [6:0] ed [94];
	logic [7:0] want [$];
	int         n_mismatch  = 0;
	int         comparisons = 0;

	always #20 clk = ~clk;
	always @(posedge clk) if (sum_error === 1'b1) err_seen <= 1'b1;

	sysex_handler #(.MAKER_ID(M), .PRODUCT_ID(P)) dut_u (.clk(clk), .rst(rst), .channel(CH), .rx_data(rx_data),
		.rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
		.knob_evt(knob_evt), .edit_evt(edit_evt), .recall_evt(recall_evt), .sum_error(sum_error));
	midi_host_model host_u (.clk(clk), .rst(rst), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
		.slow(slow));

	task check(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	// The byte is held until an edge at which ready was high; ready is read mid-cycle to avoid a race.
	task send(input logic [7:0] b);
		logic ok;
		rx_data  <= b;
		rx_valid <= 1'b1;
		do
		begin
			@(negedge clk);
			ok = rx_ready;
			@(posedge clk);
		end
		while (ok !== 1'b1);
	endtask

	task hdr(input logic [7:0] cmd, input logic [7:0] mk = M);
		send(SYX_START);
		send(mk);
		send(P);
		send(cmd);
	endtask

	// Ends a message; one idle edge keeps the valid line from being driven twice in one step.
	task fin;
		send(SYX_END);
		rx_valid <= 1'b0;
		@(posedge clk);
	endtask

	task req(input logic [7:0] cmd, input logic [7:0] ev, input logic [7:0] op);
		hdr(cmd);
		send(ev);
		send(op);
		fin();
	endtask

	task dump(input logic corrupt);
		logic [6:0] s;
		s = 7'h00;
		hdr({NIB_SETUP, CH});
		send(CNT_SETUP);
		for (int i = 0; i < 94; i++)
		begin
			send({1'b0, (i == 0 && corrupt) ? ed[i] ^ 7'h01 : ed[i]});
			s += ed[i];
		end
		send({1'b0, s});
		fin();
	endtask

	task expect_tx;
		int i;
		i = 0;
		while (host_u.got.size() < want.size() && i < 20000)
		begin
			@(posedge clk);
			i++;
		end
		repeat (20) @(posedge clk);
		check(8'(host_u.got.size()), 8'(want.size()));
		foreach (want[k]) check(host_u.got[k], want[k]);
		host_u.got.delete();
		want.delete();
	endtask

	task setup_want;
		logic [6:0] s;
		s = 7'h00;
		want = '{SYX_START, M, P, {NIB_SETUP, CH}, CNT_SETUP};
		foreach (ed[i])
		begin
			want.push_back({1'b0, ed[i]});
			s += ed[i];
		end
		want.push_back({1'b0, s});
		want.push_back(SYX_END);
	endtask

	task t_setup;
		foreach (ed[i]) ed[i] = 7'(i * 5 + 3);
		dump(1'b0);
		req({NIB_DREQ, CH}, EV_SETUP, 8'h7F);
		setup_want();
		expect_tx();
		check(err_seen, 1'b0);
		$display("test setup done");
	endtask

	task t_badsum;
		dump(1'b1);
		repeat (4) @(posedge clk);
		check(err_seen, 1'b1);
		req({NIB_DREQ, CH}, EV_SETUP, 8'h00);
		setup_want();
		expect_tx();
		$display("test bad sumcheck done");
	endtask

	// A foreign maker and a foreign channel must both draw no answer at all.
	task t_foreign;
		hdr({NIB_DREQ, CH}, 8'h12);
		send(EV_SETUP);
		send(8'h00);
		fin();
		req({NIB_DREQ, ~CH}, EV_SETUP, 8'h00);
		expect_tx();
		$display("test foreign done");
	endtask

	task t_change;
		slow <= 1'b1;
		edit_evt <= '{1'b1, 7'h03, 7'h2A};
		@(posedge clk);
		edit_evt.valid <= 1'b0;
		ed[4] = 7'h2A;
		want = '{SYX_START, M, P, {NIB_PCHG, CH}, 8'h03, 8'h2A, SYX_END};
		expect_tx();
		req({NIB_DREQ, CH}, EV_PARAM, 8'h03);
		want = '{SYX_START, M, P, {NIB_PCHG, CH}, 8'h03, 8'h2A, SYX_END};
		expect_tx();
		$display("test change done");
	endtask

	// Store skips the eight knob bytes of the edit buffer, then the stored copy is dumped back.
	task t_store;
		logic [6:0] s;
		s = 7'h00;
		req({NIB_EREQ, CH}, EV_STORE, 8'h05);
		req({NIB_DREQ, CH}, EV_ONE, 8'h05);
		want = '{SYX_START, M, P, {NIB_REG, CH}, 8'h05, CNT_REG};
		for (int k = 0; k < 57; k++)
		begin
			want.push_back({1'b0, ed[k < 24 ? k : k + 8]});
			s += ed[k < 24 ? k : k + 8];
		end
		want.push_back({1'b0, s});
		want.push_back(SYX_END);
		expect_tx();
		$display("test store done");
	endtask

	// The knob names the parameter held in the destination byte; a recall of register 5 undoes the panel edits.
	task t_panel;
		logic [6:0] keep [94];
		keep = ed;
		hdr({NIB_PCHG, CH});
		send(8'h2B);
		send(8'h05);
		fin();
		ed[44] = 7'h05;
		knob_evt <= '{1'b1, 7'h7F, 7'h11};
		@(posedge clk);
		knob_evt.valid <= 1'b0;
		ed[6] = 7'h11;
		want = '{SYX_START, M, P, {NIB_PCHG, CH}, 8'h05, 8'h11, SYX_END};
		expect_tx();
		recall_evt <= '{1'b1, PARAM_ALG, 7'h02};
		@(posedge clk);
		recall_evt.valid <= 1'b0;
		ed[0] = 7'h02;
		want = '{SYX_START, M, P, {NIB_PCHG, CH}, {1'b0, PARAM_ALG}, 8'h02, SYX_END};
		expect_tx();
		req({NIB_EREQ, CH}, EV_RECALL, 8'h05);
		ed = keep;
		req({NIB_DREQ, CH}, EV_SETUP, 8'h00);
		setup_want();
		expect_tx();
		$display("test panel done");
	endtask

	task wrap_up;
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	initial
	begin
		#2000000;
		n_mismatch++;
		wrap_up();
	end

	initial
	begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_setup();
		t_badsum();
		t_foreign();
		t_change();
		t_store();
		t_panel();
		wrap_up();
	end
endmodule

// file: hdl/byte_fifo.sv
/*
 * Small ring buffer with valid and ready on both sides.
 * Assumes both sides run on clk; the drain side may stall at will.
 */
`timescale 1ns/1ps
module byte_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 2
) (
	input  logic         clk,
	input  logic         rst,
	input  logic [W-1:0] in_data,
	input  logic         in_valid,
	output logic         in_ready,
	output logic [W-1:0] out_data,
	output logic         out_valid,
	input  logic         out_ready
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [W-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0]   cnt_q;

	function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
		return (int'(p) == DEPTH - 1) ? '0 : AW'(p + 1'b1);
	endfunction

	// Honest flags: ready drops only when every entry is taken.
	wire push = in_valid && in_ready;
	wire pop  = out_valid && out_ready;
	assign in_ready  = cnt_q != (AW+1)'(DEPTH);
	assign out_valid = cnt_q != '0;
	assign out_data  = mem_q[rd_q];

	// Pointers and fill count.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end
		else
		begin
			if (push)
				wr_q <= nxt(wr_q);
			if (pop)
				rd_q <= nxt(rd_q);
			cnt_q <= (AW+1)'(cnt_q + push - pop);
		end
	end

	// Storage needs no reset; empty entries are never shown.
	always_ff @(posedge clk)
	begin
		if (push)
			mem_q[wr_q] <= in_data;
	end

	a_fifo_count: assert property (@(posedge clk) disable iff (rst)
		push && !pop |=> cnt_q == $past(cnt_q) + 1'b1)
		else $error("fifo count did not rise on push");
	a_fifo_hold: assert property (@(posedge clk) disable iff (rst)
		out_valid && !out_ready |=> out_valid && $stable(out_data))
		else $error("fifo head changed while stalled");
endmodule

// file: hdl/param_store.sv
/*
 * Edit buffer and the 128 stored registers as plain arrays.
 * Assumes the handler never writes and reads one word in the same cycle it needs the old value.
 */
`timescale 1ns/1ps
module param_store
	import sysex_pkg::*;
(
	input  logic               clk,
	input  sysex_pkg::mem_wr_t edit_wr,
	input  sysex_pkg::mem_wr_t reg_wr,
	input  logic [6:0]         edit_raddr,
	input  logic [12:0]        reg_raddr,
	output logic [6:0]         edit_rd,
	output logic [6:0]         reg_rd
);
	logic [6:0] edit_q [LEN_SETUP];
	logic [6:0] regs_q [LEN_ALL];

	// Reads are combinational so the sequencer sees data in the address cycle.
	assign edit_rd = edit_q[edit_raddr];
	assign reg_rd  = regs_q[reg_raddr];

	// Contents are data, not control, and start undefined after power up.
	always_ff @(posedge clk)
	begin
		if (edit_wr.en)
			edit_q[edit_wr.addr[6:0]] <= edit_wr.data;
		if (reg_wr.en)
			regs_q[reg_wr.addr] <= reg_wr.data;
	end
endmodule

// file: hdl/sysex_handler.sv
/*
 * Exclusive message interpreter: parses requests and dumps, sends dumps and change messages.
 * Assumes a serial port on clk delivers and takes whole bytes with valid and ready.
 */
//
// Behaviour
// - Data request: start, maker, product, 0x3 plus channel, event, operand, end.
// - Event 60h sends setup, 61h one register, 62h parameter, 64h all registers.
// - Operand is register for 61h, parameter for 62h, otherwise ignored.
// - Event request 0x6 nibble: 70h stores edit to register, 71h recalls it.
// - Command low nibble carries channel; all units share one channel.
// - Sent and received dumps use the identical format.
// - Turning the assigned knob sends a change message for its parameter.
// - Changing a parameter in edit mode sends a change message.
// - Recalling a program from the panel sends the program change message.
// - Setup dump: nibble 0x0, count 5Eh, 94 data bytes at positions 5 to 98.
// - Setup dump: sumcheck at byte 99, end at byte 100, checked on receipt.
// - Data bytes are seven bits with the top bit zero.
// - Change message: nibble 0x2, parameter, value, end; seven bytes.
// - Register dump: nibble 0x1, register, count 39h, 57 data, sumcheck, end.
`timescale 1ns/1ps
module sysex_handler
	import sysex_pkg::*;
#(
	parameter logic [7:0] MAKER_ID   = 8'h11,	// Arbitrary value.
	parameter logic [7:0] PRODUCT_ID = 8'h22	// Arbitrary value.
) (
	input  logic                  clk,
	input  logic                  rst,
	input  logic [3:0]            channel,
	input  logic [7:0]            rx_data,
	input  logic                  rx_valid,
	output logic                  rx_ready,
	output logic [7:0]            tx_data,
	output logic                  tx_valid,
	input  logic                  tx_ready,
	input  sysex_pkg::panel_evt_t knob_evt,
	input  sysex_pkg::panel_evt_t edit_evt,
	input  sysex_pkg::panel_evt_t recall_evt,
	output logic                  sum_error
);
	import sysex_pkg::*;

	rx_state_t   rx_q;
	rx_state_t   rx_d;
	mode_t       mode_q;
	job_t        job_q;
	copy_t       copy_q;
	logic [3:0]  cmd_q;
	logic [7:0]  ev_q;
	logic [6:0]  op_q;
	logic [6:0]  val_q;
	logic [6:0]  sum_q;
	logic [6:0]  k_q;
	logic [6:0]  stage_q [LEN_SETUP];
	logic [6:0]  ck_q;
	logic [6:0]  creg_q;
	logic [13:0] pos_q;
	logic [6:0]  tsum_q;
	logic [6:0]  treg_q;
	logic [6:0]  tpar_q;
	logic [2:0]  pend_q;
	logic [6:0]  ppar_q [3];
	logic [6:0]  pval_q [3];
	logic [6:0]  edit_rd;
	logic [6:0]  reg_rd;
	logic [7:0]  push_data;
	logic        fifo_ready;
	mem_wr_t     edit_wr;
	mem_wr_t     reg_wr;
	panel_evt_t  src [3];

	// ------------------------------------------------------------
	// Receive decode
	// ------------------------------------------------------------
	// Input is only taken while idle, which also makes the parser back-pressure the port.
	assign rx_ready = mode_q == M_IDLE;
	wire       take     = rx_valid && rx_ready;
	wire       chan_ok  = rx_data[3:0] == channel;
	wire [6:0] dlen_rx  = (cmd_q == NIB_SETUP) ? 7'(LEN_SETUP) : 7'(LEN_REG);
	wire [7:0] cnt_rx   = (cmd_q == NIB_SETUP) ? CNT_SETUP : CNT_REG;
	wire       done     = take && rx_q == R_EOX && rx_data == SYX_END;
	wire       is_dump  = cmd_q == NIB_SETUP || cmd_q == NIB_REG;
	wire       dump_ok  = done && is_dump && sum_q == val_q;
	wire       bad_sum  = done && is_dump && sum_q != val_q;
	wire       req_done = done && cmd_q == NIB_DREQ;
	wire       evt_done = done && cmd_q == NIB_EREQ;
	wire       pchg_rx  = done && cmd_q == NIB_PCHG && op_q <= PARAM_LAST;

	// Next parser state; any status byte aborts, and a start byte always restarts.
	always_comb
	begin
		rx_d = R_IDLE;
		case (rx_q)
			R_MAKER: rx_d = (rx_data == MAKER_ID) ? R_PROD : R_IDLE;
			R_PROD:  rx_d = (rx_data == PRODUCT_ID) ? R_CMD : R_IDLE;
			R_CMD:
			begin
				if (chan_ok)
				begin
					case (rx_data[7:4])
						NIB_DREQ:  rx_d = R_EVENT;
						NIB_EREQ:  rx_d = R_EVENT;
						NIB_SETUP: rx_d = R_COUNT;
						NIB_REG:   rx_d = R_REGN;
						NIB_PCHG:  rx_d = R_PNUM;
						default:   rx_d = R_IDLE;
					endcase
				end
			end
			R_EVENT: rx_d = R_OPER;
			R_OPER:  rx_d = R_EOX;
			R_PNUM:  rx_d = R_PVAL;
			R_PVAL:  rx_d = R_EOX;
			R_REGN:  rx_d = R_COUNT;
			R_COUNT: rx_d = (rx_data == cnt_rx) ? R_DATA : R_IDLE;
			R_DATA:  rx_d = (k_q == 7'(dlen_rx - 7'h01)) ? R_SUM : R_DATA;
			R_SUM:   rx_d = R_EOX;
			default: rx_d = R_IDLE;
		endcase
		if (rx_data[7])
			rx_d = (rx_data == SYX_START) ? R_MAKER : R_IDLE;
	end

	// Parser registers; fields are captured by the state that owns them.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			rx_q  <= R_IDLE;
			cmd_q <= '0;
			ev_q  <= '0;
			op_q  <= '0;
			val_q <= '0;
			sum_q <= '0;
			k_q   <= '0;
		end
		else if (take)
		begin
			rx_q <= rx_d;
			case (rx_q)
				R_CMD:   cmd_q <= rx_data[7:4];
				R_EVENT: ev_q <= rx_data;
				R_OPER:  op_q <= rx_data[6:0];
				R_PNUM:  op_q <= rx_data[6:0];
				R_REGN:  op_q <= rx_data[6:0];
				R_PVAL:  val_q <= rx_data[6:0];
				R_SUM:   val_q <= rx_data[6:0];
				R_COUNT:
				begin
					k_q   <= '0;
					sum_q <= '0;
				end
				R_DATA:
				begin
					k_q   <= 7'(k_q + 7'h01);
					sum_q <= 7'(sum_q + rx_data[6:0]);
				end
				default: cmd_q <= cmd_q;
			endcase
		end
	end

	// Dumps land in staging first, so a bad sumcheck never touches memory.
	always_ff @(posedge clk)
	begin
		if (take && rx_q == R_DATA)
			stage_q[k_q] <= rx_data[6:0];
	end

	// ------------------------------------------------------------
	// Panel change sources
	// ------------------------------------------------------------
	assign src[0] = knob_evt;
	assign src[1] = edit_evt;
	assign src[2] = recall_evt;
	wire       serve     = mode_q == M_IDLE && !done && pend_q != 3'h0;
	wire [1:0] sel       = pend_q[0] ? 2'd0 : (pend_q[1] ? 2'd1 : 2'd2);
	// The knob reports the destination held in the edit buffer, not a wired number.
	wire [6:0] serve_par = (sel == 2'd0) ? edit_rd : ppar_q[sel];
	wire [6:0] serve_val = pval_q[sel];

	// One slot per source keeps the newest value; a new event wins over the clear.
	always_ff @(posedge clk)
	begin
		for (int i = 0; i < 3; i++)
		begin
			if (rst)
				pend_q[i] <= 1'b0;
			else if (src[i].valid)
			begin
				pend_q[i] <= 1'b1;
				ppar_q[i] <= src[i].param;
				pval_q[i] <= src[i].value;
			end
			else if (serve && int'(sel) == i)
				pend_q[i] <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Job dispatch
	// ------------------------------------------------------------
	wire ev_setup  = req_done && ev_q == EV_SETUP;
	wire ev_one    = req_done && ev_q == EV_ONE;
	wire ev_par    = req_done && ev_q == EV_PARAM && op_q <= PARAM_LAST;
	wire ev_all    = req_done && ev_q == EV_ALL;
	wire ev_store  = evt_done && ev_q == EV_STORE;
	wire ev_recall = evt_done && ev_q == EV_RECALL;
	wire go_tx     = ev_setup || ev_one || ev_par || ev_all || serve;
	wire go_copy   = ev_store || ev_recall || dump_ok;
	wire job_t  job_n  = ev_setup ? J_SETUP : (ev_one ? J_REG : (ev_all ? J_ALL : J_PCHG));
	wire copy_t copy_n = ev_store ? C_STORE : (ev_recall ? C_RECALL :
		((cmd_q == NIB_SETUP) ? C_SETUP : C_REG));

	// ------------------------------------------------------------
	// Transmit framing
	// ------------------------------------------------------------
	wire [1:0]  pre_len  = (job_q == J_SETUP) ? 2'd1 : 2'd2;
	wire [12:0] dlen_tx  = (job_q == J_SETUP) ? 13'(LEN_SETUP) : (job_q == J_REG) ? 13'(LEN_REG) :
		(job_q == J_ALL) ? 13'(LEN_ALL) : 13'h0000;
	wire        has_sum  = job_q != J_PCHG;
	wire [13:0] p_pre    = 14'(HDR_LEN + int'(pre_len));
	wire [13:0] p_dat    = 14'(p_pre + dlen_tx);
	wire        is_hdr   = pos_q < 14'(HDR_LEN);
	wire        is_pre   = !is_hdr && pos_q < p_pre;
	wire        is_dat   = !is_hdr && !is_pre && pos_q < p_dat;
	wire        is_sum   = has_sum && pos_q == p_dat;
	wire        tx_last  = pos_q == 14'(p_dat + has_sum);
	wire        pre_two  = pos_q != 14'(HDR_LEN);
	wire [12:0] d_idx    = 13'(pos_q - p_pre);
	wire [3:0]  tx_nib   = (job_q == J_SETUP) ? NIB_SETUP : (job_q == J_REG) ? NIB_REG :
		(job_q == J_ALL) ? NIB_ALL : NIB_PCHG;
	wire        push     = mode_q == M_TX && fifo_ready;

	// Header bytes; the low nibble always names our channel.
	wire [7:0] hdr_byte = (pos_q[1:0] == 2'd0) ? SYX_START : (pos_q[1:0] == 2'd1) ? MAKER_ID :
		(pos_q[1:0] == 2'd2) ? PRODUCT_ID : {tx_nib, channel};
	// Bytes between header and data: counts, register or parameter number, value.
	wire [7:0] pre_a    = (job_q == J_SETUP) ? CNT_SETUP : (job_q == J_REG) ? {1'b0, treg_q} :
		(job_q == J_ALL) ? CNT_ALL_HI : {1'b0, tpar_q};
	wire [7:0] pre_b    = (job_q == J_REG) ? CNT_REG : (job_q == J_ALL) ? CNT_ALL_LO : {1'b0, edit_rd};
	wire [7:0] dat_byte = {1'b0, (job_q == J_SETUP) ? edit_rd : reg_rd};
	assign push_data = is_hdr ? hdr_byte : is_pre ? (pre_two ? pre_b : pre_a) :
		is_dat ? dat_byte : is_sum ? {1'b0, tsum_q} : SYX_END;

	// ------------------------------------------------------------
	// Memory addressing
	// ------------------------------------------------------------
	wire [6:0]  copy_len = (copy_q == C_SETUP) ? 7'(LEN_SETUP) : 7'(LEN_REG);
	wire [12:0] creg_adr = 13'(reg_base(creg_q) + 13'(ck_q));
	wire [6:0]  tx_eadr  = (job_q == J_SETUP) ? d_idx[6:0] : param_byte(tpar_q);
	wire [12:0] tx_radr  = (job_q == J_REG) ? 13'(reg_base(treg_q) + d_idx) : d_idx;
	wire        cp_edit  = mode_q == M_COPY && (copy_q == C_SETUP || copy_q == C_RECALL);
	wire        cp_reg   = mode_q == M_COPY && (copy_q == C_STORE || copy_q == C_REG);
	wire [6:0]  ed_tgt   = (copy_q == C_SETUP) ? ck_q : edit_map(ck_q);
	wire [6:0]  ed_par   = param_byte(pchg_rx ? op_q : serve_par);

	// Idle reads fetch the knob destination for a pending knob message.
	wire [6:0]  edit_raddr_w;
	assign edit_raddr_w = (mode_q == M_TX) ? tx_eadr : (mode_q == M_COPY) ? edit_map(ck_q) : KNOB_DEST;
	wire [12:0] reg_raddr_w = (mode_q == M_TX) ? tx_radr : creg_adr;

	// Store copies edit to register, recall the reverse; staged dumps commit here.
	assign edit_wr.en   = cp_edit || pchg_rx || serve;
	assign edit_wr.addr = 13'(cp_edit ? ed_tgt : ed_par);
	assign edit_wr.data = cp_edit ? ((copy_q == C_SETUP) ? stage_q[ck_q] : reg_rd) :
		(pchg_rx ? val_q : serve_val);
	assign reg_wr.en    = cp_reg;
	assign reg_wr.addr  = creg_adr;
	assign reg_wr.data  = (copy_q == C_STORE) ? edit_rd : stage_q[ck_q];

	// ------------------------------------------------------------
	// Mode sequencer
	// ------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			mode_q    <= M_IDLE;
			job_q     <= J_SETUP;
			copy_q    <= C_STORE;
			pos_q     <= '0;
			tsum_q    <= '0;
			treg_q    <= '0;
			tpar_q    <= '0;
			ck_q      <= '0;
			creg_q    <= '0;
			sum_error <= 1'b0;
		end
		else
		begin
			sum_error <= bad_sum;
			case (mode_q)
				M_IDLE:
				begin
					pos_q  <= '0;
					tsum_q <= '0;
					ck_q   <= '0;
					treg_q <= op_q;
					creg_q <= op_q;
					tpar_q <= serve ? serve_par : op_q;
					job_q  <= job_n;
					copy_q <= copy_n;
					if (go_tx)
						mode_q <= M_TX;
					else if (go_copy)
						mode_q <= M_COPY;
				end
				M_TX:
				begin
					if (push)
					begin
						pos_q <= 14'(pos_q + 14'h0001);
						if (is_dat)
							tsum_q <= 7'(tsum_q + push_data[6:0]);
						if (tx_last)
							mode_q <= M_IDLE;
					end
				end
				M_COPY:
				begin
					ck_q <= 7'(ck_q + 7'h01);
					if (ck_q == 7'(copy_len - 7'h01))
						mode_q <= M_IDLE;
				end
				default: mode_q <= M_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Storage and output buffer
	// ------------------------------------------------------------
	param_store u_store (
		.clk        (clk),
		.edit_wr    (edit_wr),
		.reg_wr     (reg_wr),
		.edit_raddr (edit_raddr_w),
		.reg_raddr  (reg_raddr_w),
		.edit_rd    (edit_rd),
		.reg_rd     (reg_rd)
	);

	// A stalled serial port fills this buffer and then holds the sequencer.
	byte_fifo #(.W(8), .DEPTH(2)) u_fifo (
		.clk       (clk),
		.rst       (rst),
		.in_data   (push_data),
		.in_valid  (mode_q == M_TX),
		.in_ready  (fifo_ready),
		.out_data  (tx_data),
		.out_valid (tx_valid),
		.out_ready (tx_ready)
	);

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	sequence s_setup_req;
		req_done && ev_q == EV_SETUP;
	endsequence
	sequence s_store_req;
		evt_done && ev_q == EV_STORE;
	endsequence

	a_setup_start: assert property (s_setup_req |=> mode_q == M_TX && job_q == J_SETUP &&
		push_data == SYX_START) else $error("setup request did not start a setup dump");
	a_store_copy: assert property (s_store_req |=> (mode_q == M_COPY) ##57 (mode_q == M_IDLE))
		else $error("store copy did not last 57 cycles");
	a_setup_sum: assert property (mode_q == M_TX && job_q == J_SETUP && is_sum |-> pos_q == 14'h0063)
		else $error("setup sumcheck not at byte 99");
	a_reg_end: assert property (mode_q == M_TX && job_q == J_REG && tx_last |-> pos_q == 14'h0040)
		else $error("register dump end not at byte 64");
	a_pchg_end: assert property (mode_q == M_TX && job_q == J_PCHG && tx_last |-> pos_q == 14'h0006)
		else $error("change message end not at byte 6");
	a_msb_zero: assert property (push && !is_hdr && !tx_last |-> !push_data[7])
		else $error("body byte has top bit set");
	a_cmd_chan: assert property (push && pos_q == 14'h0003 |-> push_data[3:0] == channel && !push_data[7])
		else $error("command byte lacks channel");
	a_foreign_drop: assert property (take && rx_q == R_CMD && !rx_data[7] && !chan_ok |=> rx_q == R_IDLE)
		else $error("foreign channel not dropped");
	a_bad_sum: assert property (bad_sum |=> mode_q == M_IDLE && sum_error && !$past(edit_wr.en))
		else $error("bad sumcheck dump not dropped");
endmodule

// file: hdl/sysex_pkg.sv
/*
 * Shared constants, carriers and helpers for the exclusive message handler.
 * Assumes one system clock and a byte link framed by an outside serial port.
 */
package sysex_pkg;

	// ------------------------------------------------------------
	// Framing bytes, command nibbles and event codes
	// ------------------------------------------------------------
	localparam logic [7:0] SYX_START  = 8'hF0;
	localparam logic [7:0] SYX_END    = 8'hF7;
	localparam logic [3:0] NIB_SETUP  = 4'h0;
	localparam logic [3:0] NIB_REG    = 4'h1;
	localparam logic [3:0] NIB_PCHG   = 4'h2;
	localparam logic [3:0] NIB_DREQ   = 4'h3;
	localparam logic [3:0] NIB_ALL    = 4'h4;
	localparam logic [3:0] NIB_EREQ   = 4'h6;
	localparam logic [7:0] EV_SETUP   = 8'h60;
	localparam logic [7:0] EV_ONE     = 8'h61;
	localparam logic [7:0] EV_PARAM   = 8'h62;
	localparam logic [7:0] EV_ALL     = 8'h64;
	localparam logic [7:0] EV_STORE   = 8'h70;
	localparam logic [7:0] EV_RECALL  = 8'h71;

	// ------------------------------------------------------------
	// Dump sizes and layout
	// ------------------------------------------------------------
	localparam logic [7:0] CNT_SETUP  = 8'h5E;
	localparam logic [7:0] CNT_REG    = 8'h39;
	localparam logic [7:0] CNT_ALL_HI = 8'h39;
	localparam logic [7:0] CNT_ALL_LO = 8'h00;
	localparam int         LEN_SETUP  = 94;
	localparam int         LEN_REG    = 57;
	localparam int         LEN_ALL    = 7296;
	localparam int         HDR_LEN    = 4;
	localparam logic [6:0] KNOB_FIRST = 7'h18;
	localparam logic [6:0] KNOB_GAP   = 7'h08;
	localparam logic [6:0] KNOB_DEST  = 7'h2C;
	localparam logic [6:0] PARAM_ALG  = 7'h42;
	localparam logic [6:0] PARAM_LAST = 7'h5C;

	// ------------------------------------------------------------
	// Carriers and state types
	// ------------------------------------------------------------
	typedef struct packed {
		logic       valid;
		logic [6:0] param;
		logic [6:0] value;
	} panel_evt_t;

	typedef struct packed {
		logic        en;
		logic [12:0] addr;
		logic [6:0]  data;
	} mem_wr_t;

	typedef enum logic [3:0] {R_IDLE, R_MAKER, R_PROD, R_CMD, R_EVENT, R_OPER, R_PNUM,
		R_PVAL, R_REGN, R_COUNT, R_DATA, R_SUM, R_EOX} rx_state_t;
	typedef enum logic [1:0] {M_IDLE, M_TX, M_COPY} mode_t;
	typedef enum logic [1:0] {J_SETUP, J_REG, J_ALL, J_PCHG} job_t;
	typedef enum logic [1:0] {C_STORE, C_RECALL, C_SETUP, C_REG} copy_t;

	// ------------------------------------------------------------
	// Address helpers
	// ------------------------------------------------------------
	// Stored register byte to edit buffer byte; the edit buffer has knob bytes inserted.
	function automatic logic [6:0] edit_map(input logic [6:0] k);
		return (k < KNOB_FIRST) ? k : 7'(k + KNOB_GAP);
	endfunction

	// Parameter number to edit buffer byte.
	function automatic logic [6:0] param_byte(input logic [6:0] p);
		return (p == PARAM_ALG) ? 7'h00 : 7'(p + 7'h01);
	endfunction

	// First byte of a stored register in the flat register memory.
	function automatic logic [12:0] reg_base(input logic [6:0] r);
		return 13'(r * LEN_REG);
	endfunction

endpackage
